// *** uart_rxto_pkg.sv ***
package uart_rxto_pkg;
    // ****************************************
    // widths
    // ****************************************
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned DIV_W = 16;
    localparam int unsigned CNT_W = 5;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [ADDR_W-1:0] ADDR_DATA = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_IER = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_ISR = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_LCR = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_MCR = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_LSR = 3'h5;

    // ****************************************
    // field positions
    // ****************************************
    localparam int unsigned IER_RX = 0;
    localparam int unsigned IER_THR = 1;
    localparam int unsigned IER_LINE = 2;
    localparam int unsigned IER_MODEM = 3;
    localparam int unsigned IER_XOFF = 5;
    localparam int unsigned IER_RTS = 6;
    localparam int unsigned IER_CTS = 7;
    localparam int unsigned LCR_DLAB = 7;
    localparam int unsigned LCR_WL_LO = 0;
    localparam int unsigned MCR_PRESCALE = 7;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [DATA_W-1:0] IER_RESET = 8'h00;
    localparam logic [DATA_W-1:0] LCR_RESET = 8'h00;
    localparam logic [DATA_W-1:0] MCR_RESET = 8'h00;
    localparam logic [DIV_W-1:0] DIV_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

    // ****************************************
    // interrupt identification codes
    // ****************************************
    typedef enum logic [DATA_W-1:0] {
        ISR_NONE = 8'h01,
        ISR_LINE = 8'h06,
        ISR_RXDATA = 8'h04,
        ISR_TIMEOUT = 8'h0c,
        ISR_THR = 8'h02,
        ISR_MODEM = 8'h00,
        ISR_XOFF = 8'h10,
        ISR_FLOW = 8'h20
    } isr_code_e;

    // ****************************************
    // timing counts
    // ****************************************
    localparam logic [3:0] PRE16_LAST = 4'hf;
    localparam logic [1:0] PRE4_LAST = 2'h3;
    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [DIV_W-1:0] DIV_ONE = 16'h0001;
    localparam logic [5:0] TO_MULT = 6'h04;
    localparam logic [5:0] TO_ADD = 6'h0c;
    localparam logic [5:0] WORD_MIN = 6'h05;
endpackage : uart_rxto_pkg

// *** baud_divider.sv ***
`timescale 1ns/1ps
`default_nettype none
module baud_divider
    import uart_rxto_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // control
    input wire logic prescale4_in,
    input wire logic [uart_rxto_pkg::DIV_W-1:0] divisor_in,
    input wire logic reload_in,
    // sixteen-times enable
    output logic tick_out
);
    import uart_rxto_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [3:0] pre16;
        logic [1:0] pre4;
        logic [DIV_W-1:0] count;
        logic tick;
    } div_state_s;

    div_state_s s;
    div_state_s next_s;
    logic [DIV_W-1:0] div_last;

    // divisor zero is not legal; treat it as one so the output never stalls
    assign div_last = (divisor_in == DIV_RESET) ? DIV_RESET
                                                : divisor_in - DIV_ONE;

    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (reload_in) begin
            next_s.pre16 = 4'h0;
            next_s.pre4 = 2'h0;
            next_s.count = DIV_RESET;
        end else begin
            next_s.pre16 = s.pre16 + 4'h1;
            // leaving divide by four mid-count must not leave pre4 stuck
            if (!prescale4_in) begin
                next_s.pre4 = 2'h0;
            end
            if (s.pre16 == PRE16_LAST) begin
                if (prescale4_in && s.pre4 != PRE4_LAST) begin
                    next_s.pre4 = s.pre4 + 2'h1;
                end else begin
                    next_s.pre4 = 2'h0;
                    if (s.count >= div_last) begin
                        next_s.count = DIV_RESET;
                        next_s.tick = 1'b1;
                    end else begin
                        next_s.count = s.count + DIV_ONE;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s <= '{4'h0, 2'h0, 16'h0000, 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign tick_out = s.tick;

    // ****************************************
    // checks
    // ****************************************
    tick_gap_a: assert property (@(posedge clk_in) disable iff (rst_in)
        s.tick |=> !s.tick [*8])
        else $error("baud tick closer than the divide by sixteen allows");

    reload_restart_a: assert property (@(posedge clk_in) disable iff (rst_in)
        reload_in |=> (s.pre16 == 4'h0 && s.count == DIV_RESET && !s.tick))
        else $error("divider did not restart on latch write");

    prescale_step_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (!prescale4_in && !reload_in) |=> (s.pre4 == 2'h0))
        else $error("prescaler counted while divide by one selected");
endmodule : baud_divider
`default_nettype wire

// *** uart_rx_timeout_baud.sv ***
`timescale 1ns/1ps
`default_nettype none
module uart_rx_timeout_baud
    import uart_rxto_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // register port
    input wire logic [uart_rxto_pkg::ADDR_W-1:0] addr_in,
    input wire logic [uart_rxto_pkg::DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [uart_rxto_pkg::DATA_W-1:0] rdata_out,
    // receive path
    input wire logic [uart_rxto_pkg::CNT_W-1:0] rx_fifo_count_in,
    input wire logic [uart_rxto_pkg::CNT_W-1:0] rx_trigger_level_in,
    input wire logic rx_stop_mid_in,
    input wire logic [uart_rxto_pkg::DATA_W-1:0] rx_data_in,
    input wire logic [uart_rxto_pkg::DATA_W-1:1] line_status_in,
    input wire logic line_error_int_in,
    output logic rx_pop_out,
    // transmit path
    input wire logic thr_empty_in,
    output logic tx_write_out,
    // modem and flow events
    input wire logic modem_int_in,
    input wire logic xoff_event_in,
    input wire logic rts_event_in,
    input wire logic cts_event_in,
    // outputs to other blocks
    output logic baud_x16_output,
    output logic [uart_rxto_pkg::DATA_W-1:0] line_control_out,
    output logic [uart_rxto_pkg::DATA_W-1:0] modem_control_out,
    output logic irq_out
);
    import uart_rxto_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [DATA_W-1:0] interrupt_enable_reg;
        logic [DATA_W-1:0] line_control_reg;
        logic [DATA_W-1:0] modem_control_reg;
        logic [DIV_W-1:0] divisor;
        logic [DATA_W-1:0] rdata;
        logic [3:0] sub;
        logic [5:0] bits;
        logic timeout;
        logic thr_flag;
        logic thr_empty_q;
        logic xoff_flag;
        logic rts_flag;
        logic cts_flag;
    } main_state_s;

    main_state_s s;
    main_state_s next_s;

    // ****************************************
    // decode helpers
    // ****************************************
    function automatic logic hit(input logic stb,
                                 input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] want);
        hit = stb && (a == want);
    endfunction : hit

    function automatic logic [5:0] to_limit(input logic [1:0] wl);
        to_limit = TO_MULT * (WORD_MIN + {4'h0, wl}) + TO_ADD;
    endfunction : to_limit

    logic dlab;
    logic rhr_read;
    logic thr_write;
    logic isr_read;
    logic div_lo_wr;
    logic div_hi_wr;
    logic ier_wr;
    logic reload;
    logic rx_nonempty;
    logic rx_level;
    logic restart;
    logic expire;
    logic [5:0] limit;
    logic baud_tick;
    logic src_line;
    logic src_rxd;
    logic src_rxto;
    logic src_thr;
    logic src_modem;
    logic src_xoff;
    logic src_flow;
    isr_code_e code;

    assign dlab = s.line_control_reg[LCR_DLAB];
    assign rhr_read = hit(rd_in, addr_in, ADDR_DATA) && !dlab;
    assign thr_write = hit(wr_in, addr_in, ADDR_DATA) && !dlab;
    assign isr_read = hit(rd_in, addr_in, ADDR_ISR);
    assign div_lo_wr = hit(wr_in, addr_in, ADDR_DATA) && dlab;
    assign div_hi_wr = hit(wr_in, addr_in, ADDR_IER) && dlab;
    assign ier_wr = hit(wr_in, addr_in, ADDR_IER) && !dlab;
    assign reload = div_lo_wr || div_hi_wr;
    assign rx_nonempty = (rx_fifo_count_in != '0);
    assign rx_level = rx_nonempty
                      && (rx_fifo_count_in >= rx_trigger_level_in);
    assign limit = to_limit(s.line_control_reg[LCR_WL_LO +: 2]);
    // empty fifo holds the counter at zero, so no expiry can build up
    assign restart = rx_stop_mid_in || rhr_read || !rx_nonempty;
    assign expire = rx_nonempty && !restart && (s.bits == limit);

    // ****************************************
    // shared baud generator
    // ****************************************
    baud_divider divider (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .prescale4_in(s.modem_control_reg[MCR_PRESCALE]),
        .divisor_in(s.divisor),
        .reload_in(reload),
        .tick_out(baud_tick)
    );

    // ****************************************
    // interrupt priority
    // ****************************************
    assign src_line = s.interrupt_enable_reg[IER_LINE] && line_error_int_in;
    assign src_rxd = s.interrupt_enable_reg[IER_RX] && rx_level;
    assign src_rxto = s.interrupt_enable_reg[IER_RX] && s.timeout && rx_nonempty;
    assign src_thr = s.interrupt_enable_reg[IER_THR] && s.thr_flag;
    assign src_modem = s.interrupt_enable_reg[IER_MODEM] && modem_int_in;
    assign src_xoff = s.interrupt_enable_reg[IER_XOFF] && s.xoff_flag;
    assign src_flow = (s.interrupt_enable_reg[IER_RTS] && s.rts_flag)
                      || (s.interrupt_enable_reg[IER_CTS] && s.cts_flag);

    always_comb begin
        if (src_line) begin
            code = ISR_LINE;
        end else if (src_rxto) begin
            code = ISR_TIMEOUT;
        end else if (src_rxd) begin
            code = ISR_RXDATA;
        end else if (src_thr) begin
            code = ISR_THR;
        end else if (src_modem) begin
            code = ISR_MODEM;
        end else if (src_xoff) begin
            code = ISR_XOFF;
        end else if (src_flow) begin
            code = ISR_FLOW;
        end else begin
            code = ISR_NONE;
        end
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_s = s;
        // registers
        if (hit(wr_in, addr_in, ADDR_LCR)) begin
            next_s.line_control_reg = wdata_in;
        end
        if (hit(wr_in, addr_in, ADDR_MCR)) begin
            next_s.modem_control_reg = wdata_in;
        end
        if (ier_wr) begin
            next_s.interrupt_enable_reg = wdata_in;
        end
        if (div_lo_wr) begin
            next_s.divisor[DATA_W-1:0] = wdata_in;
        end
        if (div_hi_wr) begin
            next_s.divisor[DIV_W-1:DATA_W] = wdata_in;
        end
        // read data, valid only in the cycle after the strobe
        next_s.rdata = ZERO_BYTE;
        if (rd_in) begin
            unique case (addr_in)
                ADDR_DATA: next_s.rdata = dlab ? s.divisor[DATA_W-1:0]
                                               : rx_data_in;
                ADDR_IER: next_s.rdata = dlab ? s.divisor[DIV_W-1:DATA_W]
                                              : s.interrupt_enable_reg;
                ADDR_ISR: next_s.rdata = code;
                ADDR_LCR: next_s.rdata = s.line_control_reg;
                ADDR_MCR: next_s.rdata = s.modem_control_reg;
                ADDR_LSR: next_s.rdata = {line_status_in, rx_nonempty};
                default: next_s.rdata = ZERO_BYTE;
            endcase
        end
        // time-out counter in bit times
        if (restart) begin
            next_s.sub = 4'h0;
            next_s.bits = 6'h00;
        end else if (baud_tick) begin
            if (s.sub == TICK_LAST) begin
                next_s.sub = 4'h0;
                if (s.bits != limit) begin
                    next_s.bits = s.bits + 6'h01;
                end
            end else begin
                next_s.sub = s.sub + 4'h1;
            end
        end
        // a data read clears it; expiry cannot coincide with a read
        next_s.timeout = expire
                         || (s.timeout && !rhr_read && rx_nonempty);
        // transmit empty: set on rising edge, cleared on write or service
        next_s.thr_empty_q = thr_empty_in;
        next_s.thr_flag = (thr_empty_in && !s.thr_empty_q)
                          || (s.thr_flag && !thr_write
                              && !(isr_read && code == ISR_THR));
        // flow events: set wins over the service read
        next_s.xoff_flag = xoff_event_in
                           || (s.xoff_flag
                               && !(isr_read && code == ISR_XOFF));
        next_s.rts_flag = rts_event_in
                          || (s.rts_flag
                              && !(isr_read && code == ISR_FLOW));
        next_s.cts_flag = cts_event_in
                          || (s.cts_flag
                              && !(isr_read && code == ISR_FLOW));
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s <= '{IER_RESET, LCR_RESET, MCR_RESET, DIV_RESET, ZERO_BYTE,
                   4'h0, 6'h00, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
        end else begin
            s <= next_s;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign rdata_out = s.rdata;
    assign rx_pop_out = rhr_read && rx_nonempty;
    assign tx_write_out = thr_write;
    assign baud_x16_output = baud_tick;
    assign line_control_out = s.line_control_reg;
    assign modem_control_out = s.modem_control_reg;
    assign irq_out = (code != ISR_NONE);

    // ****************************************
    // checks
    // ****************************************
    dlab_gate_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (hit(wr_in, addr_in, ADDR_IER) && !dlab)
        |=> (s.divisor == $past(s.divisor) && s.interrupt_enable_reg == $past(wdata_in)))
        else $error("divisor latch changed while latch access was off");

    empty_no_to_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !rx_nonempty |-> (code != ISR_TIMEOUT))
        else $error("time-out reported with an empty receive fifo");

    to_restart_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (rx_stop_mid_in || rhr_read) |=> (s.bits == 6'h00 && s.sub == 4'h0))
        else $error("time-out count did not restart");

    to_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
        rhr_read |=> !s.timeout)
        else $error("time-out flag survived a data read");

    to_expire_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (rx_nonempty && !restart && s.bits == limit) |=> s.timeout)
        else $error("time-out did not fire at its limit");

    to_limit_a: assert property (@(posedge clk_in) disable iff (rst_in)
        s.bits <= to_limit(s.line_control_reg[LCR_WL_LO +: 2]) + 6'h01)
        else $error("time-out count ran past its limit");

    flow_lowest_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (code == ISR_FLOW)
        |-> !(src_line || src_rxd || src_rxto || src_thr
              || src_modem || src_xoff))
        else $error("flow interrupt shown over a higher one");

    rx_shared_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (src_rxd && !src_line && !src_rxto) |-> (code == ISR_RXDATA))
        else $error("receive data interrupt not reported");

    thr_reset_a: assert property (@(posedge clk_in) disable iff (rst_in)
        $fell(rst_in) |-> s.thr_flag)
        else $error("transmit empty not pending after reset");

    thr_service_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (isr_read && code == ISR_THR && s.thr_empty_q) |=> !s.thr_flag)
        else $error("transmit empty interrupt not cleared by service");

    flow_enable_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (code == ISR_XOFF) |-> s.interrupt_enable_reg[IER_XOFF])
        else $error("xoff interrupt shown while disabled");

    single_code_a: assert property (@(posedge clk_in) disable iff (rst_in)
        rd_in && addr_in == ADDR_ISR
        |=> (s.rdata inside {ISR_NONE, ISR_LINE, ISR_RXDATA, ISR_TIMEOUT,
                             ISR_THR, ISR_MODEM, ISR_XOFF, ISR_FLOW}))
        else $error("status showed more than one source");

    prescale_route_a: assert property (@(posedge clk_in) disable iff (rst_in)
        hit(wr_in, addr_in, ADDR_MCR)
        |=> s.modem_control_reg[MCR_PRESCALE] == $past(wdata_in[MCR_PRESCALE]))
        else $error("prescale select not taken");

    reload_on_write_a: assert property (@(posedge clk_in) disable iff (rst_in)
        reload |=> !baud_tick [*8])
        else $error("baud tick right after a latch write");
endmodule : uart_rx_timeout_baud
`default_nettype wire

// *** host_bus_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host processor on the register port
// ****************************************
module host_bus_model
    import uart_rxto_pkg::*;
(
    // clock
    input wire logic clk_in,
    // register port
    output logic [uart_rxto_pkg::ADDR_W-1:0] addr_out,
    output logic [uart_rxto_pkg::DATA_W-1:0] wdata_out,
    output logic wr_out,
    output logic rd_out,
    input wire logic [uart_rxto_pkg::DATA_W-1:0] rdata_in
);
    initial begin
        addr_out = 3'h0;
        wdata_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    // one-cycle strobe; data inverted after so stale bytes never match
    task write_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
        wdata_out <= ~d;
    endtask : write_reg
    // read data stand only in the cycle after the strobe
    task read_reg(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        #1 d = rdata_in;
    endtask : read_reg
    // take one byte, then look again for more waiting
    task fetch_byte(output logic [7:0] d, output logic more);
        logic [7:0] s;
        read_reg(ADDR_DATA, d);
        read_reg(ADDR_LSR, s);
        more = s[0];
    endtask : fetch_byte
endmodule : host_bus_model
`default_nettype wire

// *** test_uart_rx_timeout_and_baud_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_uart_rx_timeout_and_baud_gen;
    import uart_rxto_pkg::*;
    typedef struct {
        logic [ADDR_W-1:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } row_s;
    row_s rows [6] = '{'{3'h3, 8'h03, 8'h03}, '{3'h4, 8'h80, 8'h80},
        '{3'h1, 8'he1, 8'he1}, '{3'h6, 8'hff, 8'h00},
        '{3'h7, 8'h5a, 8'h00}, '{3'h1, 8'h00, 8'h00}};
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata, rdata, line_control_reg, modem_control_reg, v;
    logic wr, rd, baud, pop, txw, irq, m;
    logic [CNT_W-1:0] cnt = 5'h00;
    logic [CNT_W-1:0] trig = 5'h04;
    logic mid = 1'b0;
    logic xoff = 1'b0;
    logic cts = 1'b0;
    logic rts = 1'b0;
    logic lerr = 1'b0;
    logic modem = 1'b0;
    logic thr = 1'b1;
    int err_total = 0;
    int checked = 0;
    int pops = 0;
    int txws = 0;
    int n;
    // ****************************************
    // design and host
    // ****************************************
    uart_rx_timeout_baud DUT (.clk_in(clk_in), .rst_in(rst_in),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .rx_fifo_count_in(cnt),
        .rx_trigger_level_in(trig), .rx_stop_mid_in(mid),
        .rx_data_in(8'ha5), .line_status_in(7'h30),
        .line_error_int_in(lerr), .rx_pop_out(pop),
        .thr_empty_in(thr), .tx_write_out(txw), .modem_int_in(modem),
        .xoff_event_in(xoff), .rts_event_in(rts), .cts_event_in(cts),
        .baud_x16_output(baud), .line_control_out(line_control_reg),
        .modem_control_out(modem_control_reg), .irq_out(irq));
    host_bus_model u_host (.clk_in(clk_in), .addr_out(addr),
        .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .rdata_in(rdata));
    always #4 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        if (pop === 1'b1) pops++;
        if (txw === 1'b1) txws++;
    end
    // ****************************************
    // helpers
    // ****************************************
    task check(input string s, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", s, e, g);
            err_total++;
        end
    endtask : check
    task ck(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        logic [7:0] g;
        u_host.read_reg(a, g);
        check("register read", {8'h00, e}, {8'h00, g});
    endtask : ck
    // cycles between two baud pulses, bounded
    task period(output int c);
        c = 0;
        do begin @(posedge clk_in); #1 c++; end
        while (baud !== 1'b1 && c < 9000);
        c = 0;
        do begin @(posedge clk_in); #1 c++; end
        while (baud !== 1'b1 && c < 9000);
    endtask : period
    task give_verdict;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (12) @(posedge clk_in);
        check("reset rdata", 16'h0000, {8'h00, rdata});
        check("reset irq", 16'h0000, {15'h0000, irq});
        rst_in <= 1'b0;
        foreach (rows[i]) begin
            u_host.write_reg(rows[i].a, rows[i].d);
            ck(rows[i].a, rows[i].e);
        end
        check("line control", 16'h0003, {8'h00, line_control_reg});
        check("modem control", 16'h0080, {8'h00, modem_control_reg});
        $display("test registers done");
        u_host.write_reg(ADDR_MCR, 8'h00);
        u_host.write_reg(ADDR_IER, 8'hef);
        @(posedge clk_in);
        cnt <= 5'h05;
        lerr <= 1'b1;
        modem <= 1'b1;
        xoff <= 1'b1;
        cts <= 1'b1;
        @(posedge clk_in);
        xoff <= 1'b0;
        cts <= 1'b0;
        ck(ADDR_ISR, ISR_LINE);
        lerr <= 1'b0;
        ck(ADDR_ISR, ISR_RXDATA);
        ck(ADDR_LSR, 8'h61);
        @(posedge clk_in);
        cnt <= 5'h00;
        ck(ADDR_ISR, ISR_THR);
        ck(ADDR_ISR, ISR_MODEM);
        modem <= 1'b0;
        ck(ADDR_ISR, ISR_XOFF);
        check("irq", 16'h0001, {15'h0000, irq});
        ck(ADDR_ISR, ISR_FLOW);
        ck(ADDR_ISR, ISR_NONE);
        rts <= 1'b1;
        @(posedge clk_in);
        rts <= 1'b0;
        ck(ADDR_ISR, ISR_FLOW);
        ck(ADDR_ISR, ISR_NONE);
        $display("test priority done");
        u_host.write_reg(ADDR_LCR, 8'h80);
        u_host.write_reg(ADDR_DATA, 8'h03);
        ck(ADDR_DATA, 8'h03);
        period(n);
        check("period x1", 16'd48, n[15:0]);
        u_host.write_reg(ADDR_MCR, 8'h80);
        period(n);
        check("period x4", 16'd192, n[15:0]);
        u_host.write_reg(ADDR_MCR, 8'h00);
        u_host.write_reg(ADDR_IER, 8'h01);
        ck(ADDR_IER, 8'h01);
        period(n);
        check("period high", 16'd4144, n[15:0]);
        u_host.write_reg(ADDR_IER, 8'h00);
        u_host.write_reg(ADDR_DATA, 8'h01);
        u_host.write_reg(ADDR_LCR, 8'h00);
        $display("test baud done");
        u_host.write_reg(ADDR_IER, 8'h01);
        @(posedge clk_in);
        cnt <= 5'h01;
        trig <= 5'h08;
        repeat (7800) @(posedge clk_in);
        ck(ADDR_ISR, ISR_NONE);
        repeat (600) @(posedge clk_in);
        ck(ADDR_ISR, ISR_TIMEOUT);
        u_host.fetch_byte(v, m);
        check("rx data", 16'h00a5, {8'h00, v});
        check("more data", 16'h0001, {15'h0000, m});
        ck(ADDR_ISR, ISR_NONE);
        repeat (5000) @(posedge clk_in);
        mid <= 1'b1;
        @(posedge clk_in);
        mid <= 1'b0;
        repeat (4000) @(posedge clk_in);
        ck(ADDR_ISR, ISR_NONE);
        repeat (4400) @(posedge clk_in);
        ck(ADDR_ISR, ISR_TIMEOUT);
        @(posedge clk_in);
        cnt <= 5'h00;
        ck(ADDR_ISR, ISR_NONE);
        $display("test time-out done");
        u_host.write_reg(ADDR_IER, 8'h02);
        u_host.write_reg(ADDR_DATA, 8'h3c);
        ck(ADDR_ISR, ISR_NONE);
        thr <= 1'b0;
        @(posedge clk_in);
        thr <= 1'b1;
        ck(ADDR_ISR, ISR_THR);
        check("data writes", 16'h0001, txws[15:0]);
        check("data reads", 16'h0001, pops[15:0]);
        $display("test transmit done");
        give_verdict();
    end
    // hang guard, well beyond the some 31000 cycles the tests need
    initial begin
        repeat (60000) @(posedge clk_in);
        err_total++;
        give_verdict();
    end
endmodule : test_uart_rx_timeout_and_baud_gen
`default_nettype wire
